// ### logic/bsad_top.sv
// Boot section decode, pointer mapping and read-while-write guard
`timescale 1ns/10ps
`default_nettype none
`include "bsad_defines.svh"

module bsad_top #(
    parameter bit BIG = 1'b0
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    // Fuse setting
    input  wire bsad_pkg::bsad_sel_t  boot_size_sel,
    // CPU self-programming requests
    input  wire bsad_pkg::bsad_ptr_t  flash_pointer_reg,
    input  wire logic                 spm_erase,
    input  wire logic                 spm_write,
    input  wire logic                 spm_load,
    input  wire logic                 spm_rww_reenable,
    input  wire logic                 lpm_read,
    // CPU fetch and data reads of flash
    input  wire logic                 fetch_req,
    input  wire bsad_pkg::bsad_addr_t fetch_addr,
    // Flash array completion
    input  wire logic                 prog_done,
    // Section boundaries
    output bsad_pkg::bsad_addr_t      boot_reset_addr,
    output bsad_pkg::bsad_addr_t      boot_end_addr,
    output bsad_pkg::bsad_addr_t      app_end_addr,
    output logic [10:0]               boot_words,
    output logic [5:0]                boot_pages,
    // Flash array commands
    output logic                      erase_go,
    output logic                      write_go,
    output bsad_pkg::bsad_page_t      prog_page,
    output logic                      buf_word_we,
    output bsad_pkg::bsad_word_t      buf_word_idx,
    output bsad_pkg::bsad_addr_t      lpm_addr,
    output logic                      lpm_hi_byte,
    // Status toward the CPU
    output logic                      rww_busy_flag,
    output logic                      rww_access_blocked,
    output logic                      cpu_stall
);
    import bsad_pkg::*;

    // Fuse synchroniser; the fuse is static so two flops are only a guard
    bsad_sel_t   sel_meta;
    bsad_sel_t   sel_sync;
    // Decoder and mapper outputs
    bsad_addr_t  dec_start;
    bsad_addr_t  dec_end;
    bsad_addr_t  dec_app_end;
    logic [10:0] dec_words;
    logic [5:0]  dec_pages;
    bsad_addr_t  ptr_addr;
    bsad_page_t  ptr_page;
    bsad_word_t  ptr_word;
    logic        ptr_byte;
    // Sequencer
    bsad_state_e state;
    bsad_state_e next_state;
    logic        next_rww_busy_flag;
    logic        next_erase_go;
    logic        next_write_go;
    bsad_page_t  next_prog_page;
    logic        next_buf_word_we;
    bsad_word_t  next_buf_word_idx;
    bsad_addr_t  next_lpm_addr;
    logic        next_lpm_hi_byte;
    logic        next_rww_access_blocked;
    logic        start_op;
    logic        target_rww;

    // True when a word address falls in the read-while-write region
    function automatic logic in_rww(input bit big, input bsad_addr_t a);
        return a < (big ? `BSAD_RWW_LIMIT_8K : `BSAD_RWW_LIMIT_4K);
    endfunction

    // Variant fixed by BIG at build time
    bsad_boot_decode #(.BIG(BIG)) u_dec (
        .boot_size_sel (sel_sync),
        .boot_start    (dec_start),
        .boot_end      (dec_end),
        .app_end       (dec_app_end),
        .boot_words    (dec_words),
        .boot_pages    (dec_pages)
    );

    bsad_ptr_map #(.BIG(BIG)) u_ptr (
        .flash_pointer_reg (flash_pointer_reg),
        .word_addr         (ptr_addr),
        .page_number_field (ptr_page),
        .word_index_field  (ptr_word),
        .byte_sel          (ptr_byte)
    );

    // Two-flop fuse synchroniser
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sel_meta <= `BSAD_RST_SEL;
            sel_sync <= `BSAD_RST_SEL;
        end else begin
            sel_meta <= boot_size_sel;
            sel_sync <= sel_meta;
        end
    end

    // Boundaries are registered so they stand clean between fuse changes
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            boot_reset_addr <= `BSAD_RST_ADDR;
            boot_end_addr   <= `BSAD_RST_ADDR;
            app_end_addr    <= `BSAD_RST_ADDR;
            boot_words      <= 11'h000;
            boot_pages      <= 6'h00;
        end else begin
            boot_reset_addr <= dec_start;
            boot_end_addr   <= dec_end;
            app_end_addr    <= dec_app_end;
            boot_words      <= dec_words;
            boot_pages      <= dec_pages;
        end
    end

    // Requests are taken only while idle; a request during programming is dropped
    assign start_op   = (state == BSAD_IDLE) && (spm_erase || spm_write);
    assign target_rww = in_rww(BIG, ptr_addr);
    assign cpu_stall  = (state == BSAD_PROG_REGA);

    // Sequencer next values
    always_comb begin
        next_state              = state;
        next_rww_busy_flag      = rww_busy_flag;
        next_erase_go           = 1'b0;
        next_write_go           = 1'b0;
        next_prog_page          = prog_page;
        next_buf_word_we        = 1'b0;
        next_buf_word_idx       = buf_word_idx;
        next_lpm_addr           = lpm_addr;
        next_lpm_hi_byte        = lpm_hi_byte;
        next_rww_access_blocked = fetch_req && rww_busy_flag && in_rww(BIG, fetch_addr);
        unique case (state)
            BSAD_IDLE: begin
                // Re-enable and buffer load both release the busy flag
                if (spm_rww_reenable || spm_load) begin
                    next_rww_busy_flag = 1'b0;
                end
                if (spm_load && !start_op) begin
                    next_buf_word_we  = 1'b1;
                    next_buf_word_idx = ptr_word;
                end
                // A new rww_region operation wins over a same-cycle release
                if (start_op) begin
                    next_erase_go  = spm_erase;
                    next_write_go  = spm_write && !spm_erase;
                    next_prog_page = ptr_page;
                    if (target_rww) begin
                        next_rww_busy_flag = 1'b1;
                        next_state         = BSAD_PROG_RWW;
                    end else begin
                        next_state = BSAD_PROG_REGA;
                    end
                end
            end
            BSAD_PROG_RWW, BSAD_PROG_REGA: begin
                if (prog_done) begin
                    next_state = BSAD_IDLE;
                end
            end
        endcase
        // Reads still decode while rww_region programs; blocking is flagged apart
        if (lpm_read) begin
            next_lpm_addr    = ptr_addr;
            next_lpm_hi_byte = ptr_byte;
        end
    end

    // Sequencer registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state              <= BSAD_IDLE;
            rww_busy_flag      <= 1'b0;
            erase_go           <= 1'b0;
            write_go           <= 1'b0;
            prog_page          <= 7'h00;
            buf_word_we        <= 1'b0;
            buf_word_idx       <= 6'h00;
            lpm_addr           <= `BSAD_RST_ADDR;
            lpm_hi_byte        <= 1'b0;
            rww_access_blocked <= 1'b0;
        end else begin
            state              <= next_state;
            rww_busy_flag      <= next_rww_busy_flag;
            erase_go           <= next_erase_go;
            write_go           <= next_write_go;
            prog_page          <= next_prog_page;
            buf_word_we        <= next_buf_word_we;
            buf_word_idx       <= next_buf_word_idx;
            lpm_addr           <= next_lpm_addr;
            lpm_hi_byte        <= next_lpm_hi_byte;
            rww_access_blocked <= next_rww_access_blocked;
        end
    end

    // Boot section runs from its start up to the last flash word
    property p_boot_span;
        @(posedge clk) disable iff (!rst_b)
        $past(rst_b) |-> (app_end_addr + 13'h0001 == boot_reset_addr)
            && (boot_end_addr == (BIG ? 13'h1FFF : 13'h0FFF));
    endproperty
    a_boot_span: assert property (p_boot_span)
        else $error("boot section span wrong");

    // Fuse 11 yields the smallest section at the top of flash
    property p_boot_start;
        @(posedge clk) disable iff (!rst_b)
        (sel_sync == 2'b11) ##1 (sel_sync == 2'b11)
            |-> boot_reset_addr == (BIG ? 13'h1F80 : 13'h0F80) && boot_words == 11'h080;
    endproperty
    a_boot_start: assert property (p_boot_start)
        else $error("boot start for setting 11 wrong");

    // Largest section starts where region_a starts
    property p_boot_big;
        @(posedge clk) disable iff (!rst_b)
        (sel_sync == 2'b00) ##1 (sel_sync == 2'b00)
            |-> boot_reset_addr == (BIG ? 13'h1C00 : 13'h0C00)
            && boot_pages == (BIG ? 6'd16 : 6'd32);
    endproperty
    a_boot_big: assert property (p_boot_big)
        else $error("boot start for setting 00 wrong");

    // Page and erase target latch from the pointer
    property p_page_target;
        @(posedge clk) disable iff (!rst_b)
        start_op |=> (erase_go || write_go)
            && prog_page == (BIG ? $past(flash_pointer_reg[13:7]) : $past(flash_pointer_reg[12:6]))
            ##1 !erase_go && !write_go;
    endproperty
    a_page_target: assert property (p_page_target)
        else $error("page target not taken from pointer");

    // Buffer word index follows the pointer
    property p_buf_load;
        @(posedge clk) disable iff (!rst_b)
        (spm_load && state == BSAD_IDLE && !start_op) |=> buf_word_we
            && buf_word_idx == (BIG ? $past(flash_pointer_reg[6:1]) : {1'b0, $past(flash_pointer_reg[5:1])});
    endproperty
    a_buf_load: assert property (p_buf_load)
        else $error("buffer word index wrong");

    // Read address drops pointer bit 0 and the unused upper bits
    property p_lpm_map;
        @(posedge clk) disable iff (!rst_b)
        lpm_read |=> lpm_hi_byte == $past(flash_pointer_reg[0])
            && lpm_addr == (BIG ? $past(flash_pointer_reg[13:1]) : {1'b0, $past(flash_pointer_reg[12:1])});
    endproperty
    a_lpm_map: assert property (p_lpm_map)
        else $error("read address or byte select wrong");

    // Programming into rww_region raises the busy flag until released
    property p_busy_set;
        @(posedge clk) disable iff (!rst_b)
        (start_op && target_rww) |=> rww_busy_flag && state == BSAD_PROG_RWW;
    endproperty
    a_busy_set: assert property (p_busy_set)
        else $error("busy flag not set for rww_region programming");

    // A fetch into a busy rww_region is blocked next cycle
    property p_block;
        @(posedge clk) disable iff (!rst_b)
        (fetch_req && rww_busy_flag && fetch_addr < (BIG ? 13'h1C00 : 13'h0C00)) |=> rww_access_blocked;
    endproperty
    a_block: assert property (p_block)
        else $error("rww_region access not blocked");

    // Programming region_a stalls the CPU and leaves the busy flag alone
    property p_stall;
        @(posedge clk) disable iff (!rst_b)
        (start_op && !target_rww) |=> cpu_stall && !$rose(rww_busy_flag);
    endproperty
    a_stall: assert property (p_stall)
        else $error("CPU not stalled for region_a programming");

    // The stall lasts until the array reports completion
    property p_stall_hold;
        @(posedge clk) disable iff (!rst_b)
        (cpu_stall && !prog_done) |=> cpu_stall;
    endproperty
    a_stall_hold: assert property (p_stall_hold)
        else $error("CPU stall released before programming finished");
endmodule

`default_nettype wire

// ### inc/bsad_defines.svh
// Constants for the boot section address decode block
`ifndef BSAD_DEFINES_SVH
`define BSAD_DEFINES_SVH

// Field widths shared by both variants
`define BSAD_ADDR_W         13
`define BSAD_PAGE_W         7
`define BSAD_WORD_W         6
`define BSAD_PTR_W          16

// Page word field position (number of word bits)
`define BSAD_PAGE_LSB_4K    3'd5
`define BSAD_PAGE_LSB_8K    3'd6

// Last word of flash, where every boot section ends
`define BSAD_BOOT_END_4K    13'h0FFF
`define BSAD_BOOT_END_8K    13'h1FFF

// Boot reset address per boot size setting, 4K-word variant
`define BSAD_BOOT_4K_S3     13'h0F80
`define BSAD_BOOT_4K_S2     13'h0F00
`define BSAD_BOOT_4K_S1     13'h0E00
`define BSAD_BOOT_4K_S0     13'h0C00

// Boot reset address per boot size setting, 8K-word variant
`define BSAD_BOOT_8K_S3     13'h1F80
`define BSAD_BOOT_8K_S2     13'h1F00
`define BSAD_BOOT_8K_S1     13'h1E00
`define BSAD_BOOT_8K_S0     13'h1C00

// First word of the no-read-while-write region
`define BSAD_RWW_LIMIT_4K   13'h0C00
`define BSAD_RWW_LIMIT_8K   13'h1C00

// Smallest boot section in words, for setting 11
`define BSAD_BOOT_MIN_WORDS 11'h080

// Reset values
`define BSAD_RST_ADDR       13'h0000
`define BSAD_RST_SEL        2'h0

`endif

// ### inc/bsad_pkg.sv
// Types for the boot section address decode block
`include "bsad_defines.svh"

package bsad_pkg;
    typedef logic [`BSAD_ADDR_W-1:0] bsad_addr_t;
    typedef logic [`BSAD_PAGE_W-1:0] bsad_page_t;
    typedef logic [`BSAD_WORD_W-1:0] bsad_word_t;
    typedef logic [`BSAD_PTR_W-1:0]  bsad_ptr_t;
    typedef logic [1:0]              bsad_sel_t;

    // Programming sequencer states
    typedef enum logic [1:0] {
        BSAD_IDLE,
        BSAD_PROG_RWW,
        BSAD_PROG_REGA
    } bsad_state_e;
endpackage

// ### logic/bsad_boot_decode.sv
// Boot size fuse decode into section boundaries
`timescale 1ns/10ps
`default_nettype none
`include "bsad_defines.svh"

module bsad_boot_decode #(
    parameter bit BIG = 1'b0
) (
    // Fuse setting
    input  wire bsad_pkg::bsad_sel_t  boot_size_sel,
    // Section boundaries
    output bsad_pkg::bsad_addr_t      boot_start,
    output bsad_pkg::bsad_addr_t      boot_end,
    output bsad_pkg::bsad_addr_t      app_end,
    output logic [10:0]               boot_words,
    output logic [5:0]                boot_pages
);
    import bsad_pkg::*;

    // Table lookup of the boot reset address
    function automatic bsad_addr_t boot_start_of(input bit big, input bsad_sel_t sel);
        bsad_addr_t a;
        a = `BSAD_RST_ADDR;
        unique case (sel)
            2'b11: a = big ? `BSAD_BOOT_8K_S3 : `BSAD_BOOT_4K_S3;
            2'b10: a = big ? `BSAD_BOOT_8K_S2 : `BSAD_BOOT_4K_S2;
            2'b01: a = big ? `BSAD_BOOT_8K_S1 : `BSAD_BOOT_4K_S1;
            2'b00: a = big ? `BSAD_BOOT_8K_S0 : `BSAD_BOOT_4K_S0;
        endcase
        return a;
    endfunction

    // Size doubles for each step the setting goes down
    always_comb begin
        boot_start = boot_start_of(BIG, boot_size_sel);
        boot_end   = BIG ? `BSAD_BOOT_END_8K : `BSAD_BOOT_END_4K;
        app_end    = boot_start - 13'h0001;
        boot_words = `BSAD_BOOT_MIN_WORDS << (~boot_size_sel);
        boot_pages = 6'(boot_words >> (BIG ? `BSAD_PAGE_LSB_8K : `BSAD_PAGE_LSB_4K));
    end
endmodule

`default_nettype wire

// ### logic/bsad_ptr_map.sv
// Flash pointer split into page, word and byte fields
`timescale 1ns/10ps
`default_nettype none

module bsad_ptr_map #(
    parameter bit BIG = 1'b0
) (
    // Pointer from the CPU
    input  wire bsad_pkg::bsad_ptr_t  flash_pointer_reg,
    // Decoded fields
    output bsad_pkg::bsad_addr_t      word_addr,
    output bsad_pkg::bsad_page_t      page_number_field,
    output bsad_pkg::bsad_word_t      word_index_field,
    output logic                      byte_sel
);
    import bsad_pkg::*;

    // Pointer bit n+1 carries word address bit n; upper pointer bits dropped
    always_comb begin
        if (BIG) begin
            word_addr         = flash_pointer_reg[13:1];
            page_number_field = flash_pointer_reg[13:7];
            word_index_field  = flash_pointer_reg[6:1];
        end else begin
            word_addr         = {1'b0, flash_pointer_reg[12:1]};
            page_number_field = flash_pointer_reg[12:6];
            word_index_field  = {1'b0, flash_pointer_reg[5:1]};
        end
        byte_sel = flash_pointer_reg[0];
    end
endmodule

`default_nettype wire

// ### logic/bsad_unused_placeholder.sv
// Intentionally empty design unit kept out of the build
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ### dv/bsad_flash_model.sv
// Flash array model that answers erase and write commands after a set delay
`timescale 1ns/10ps
`default_nettype none

module bsad_flash_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Commands from the sequencer
    input  wire logic       erase_go,
    input  wire logic       write_go,
    // Busy time in cycles, small for a prompt array, large for a slow one
    input  wire logic [7:0] busy_cycles,
    // Completion back to the sequencer
    output logic            prog_done
);
    logic [7:0] count;
    logic [7:0] next_count;
    logic       next_done;

    // Count down from each command; done is a single-cycle pulse
    always_comb begin
        next_count = count;
        next_done  = 1'b0;
        if (erase_go || write_go) begin
            next_count = busy_cycles;
        end else if (count == 8'h01) begin
            next_count = 8'h00;
            next_done  = 1'b1;
        end else if (count != 8'h00) begin
            next_count = count - 8'h01;
        end
    end

    // A delay of zero would never finish, so callers keep it above zero
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            count     <= 8'h00;
            prog_done <= 1'b0;
        end else begin
            count     <= next_count;
            prog_done <= next_done;
        end
    end
endmodule
`default_nettype wire

// ### dv/test_boot_section_address_decode.sv
// Self-checking bench for both flash size variants side by side
`timescale 1ns/10ps
`default_nettype none

module test_boot_section_address_decode;
    import bsad_pkg::*;

    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    bsad_sel_t   sel = 2'h0;
    bsad_ptr_t   ptr = 16'h0000;
    logic        erase = 1'b0;
    logic        write = 1'b0;
    logic        load = 1'b0;
    logic        reen = 1'b0;
    logic        lpm = 1'b0;
    logic        freq = 1'b0;
    bsad_addr_t  faddr = 13'h0000;
    logic [7:0]  busy_cycles = 8'h01;
    bsad_addr_t  b_start [2];
    bsad_addr_t  b_end [2];
    bsad_addr_t  a_end [2];
    bsad_addr_t  l_addr [2];
    logic [10:0] b_words [2];
    logic [5:0]  b_pages [2];
    bsad_page_t  pg [2];
    bsad_word_t  idx [2];
    logic        e_go [2];
    logic        w_go [2];
    logic        we [2];
    logic        hi [2];
    logic        busy [2];
    logic        blk [2];
    logic        stall [2];
    logic        done [2];
    int          fail_count = 0;
    int          cmp_count = 0;

    always #12.5 clk = ~clk;

    // Index 0 is the small variant, index 1 the large one; both see the same CPU
    for (genvar g = 0; g < 2; g++) begin : gen_var
        bsad_top #(.BIG(g == 1)) dut (
            .clk(clk), .rst_b(rst_b), .boot_size_sel(sel), .flash_pointer_reg(ptr),
            .spm_erase(erase), .spm_write(write), .spm_load(load), .spm_rww_reenable(reen),
            .lpm_read(lpm), .fetch_req(freq), .fetch_addr(faddr), .prog_done(done[g]),
            .boot_reset_addr(b_start[g]), .boot_end_addr(b_end[g]), .app_end_addr(a_end[g]),
            .boot_words(b_words[g]), .boot_pages(b_pages[g]), .erase_go(e_go[g]),
            .write_go(w_go[g]), .prog_page(pg[g]), .buf_word_we(we[g]), .buf_word_idx(idx[g]),
            .lpm_addr(l_addr[g]), .lpm_hi_byte(hi[g]), .rww_busy_flag(busy[g]),
            .rww_access_blocked(blk[g]), .cpu_stall(stall[g])
        );
        bsad_flash_model model (
            .clk(clk), .rst_b(rst_b), .erase_go(e_go[g]), .write_go(w_go[g]),
            .busy_cycles(busy_cycles), .prog_done(done[g])
        );
    end

    // Inputs change a fixed 2 ns after the rising edge
    task automatic step();
        @(posedge clk);
        #2;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Word address seen through the pointer; top pointer bits must drop out
    function automatic bsad_addr_t waddr(input int g, input bsad_ptr_t p);
        return (g == 1) ? p[13:1] : {1'b0, p[12:1]};
    endfunction

    function automatic bsad_addr_t limit(input int g);
        return (g == 1) ? 13'h1C00 : 13'h0C00;
    endfunction

    // Fuse is static, so each setting gets its own reset
    task automatic t_bounds();
        logic [10:0] w;
        for (int s = 0; s < 4; s++) begin
            rst_b = 1'b0;
            sel = s[1:0];
            repeat (12) step();
            rst_b = 1'b1;
            repeat (4) step();
            w = 11'h080 << (3 - s);
            for (int g = 0; g < 2; g++) begin
                check("boot_words", b_words[g], w);
                check("boot_pages", b_pages[g], (g == 1) ? w >> 6 : w >> 5);
                check("boot_end_addr", b_end[g], (g == 1) ? 13'h1FFF : 13'h0FFF);
                check("boot_reset_addr", b_start[g], ((g == 1) ? 14'h2000 : 14'h1000) - w);
                check("app_end_addr", a_end[g], ((g == 1) ? 14'h1FFF : 14'h0FFF) - w);
            end
        end
    endtask

    // Reads split the pointer into word and byte, loads pick a buffer word
    task automatic t_pointer();
        bsad_ptr_t pl [4] = '{16'hFFFF, 16'h5AA5, 16'h2041, 16'hC03E};
        foreach (pl[i]) begin
            ptr = pl[i];
            lpm = 1'b1;
            step();
            lpm = 1'b0;
            ptr = pl[i] & 16'hFFFE;
            load = 1'b1;
            for (int g = 0; g < 2; g++) begin
                check("lpm_addr", l_addr[g], waddr(g, pl[i]));
                check("lpm_hi_byte", hi[g], pl[i][0]);
            end
            step();
            load = 1'b0;
            for (int g = 0; g < 2; g++) begin
                check("buf_word_we", we[g], 1'b1);
                check("buf_word_idx", idx[g], (g == 1) ? pl[i][6:1] : {1'b0, pl[i][5:1]});
            end
        end
    endtask

    // One erase or write, its completion, the fetch guard and the release
    task automatic t_prog(input bsad_ptr_t p, input logic is_wr, input logic [7:0] d);
        logic       rww_region [2];
        int         n;
        bsad_addr_t fa [2] = '{13'h0BFF, 13'h0C00};
        ptr = p;
        busy_cycles = d;
        write = is_wr;
        erase = !is_wr;
        step();
        write = 1'b0;
        erase = 1'b0;
        for (int g = 0; g < 2; g++) begin
            rww_region[g] = waddr(g, p) < limit(g);
            check("write_go", w_go[g], is_wr);
            check("erase_go", e_go[g], !is_wr);
            check("prog_page", pg[g], (g == 1) ? p[13:7] : p[12:6]);
            check("cpu_stall", stall[g], !rww_region[g]);
            check("rww_busy_flag", busy[g], rww_region[g]);
        end
        step();
        for (int g = 0; g < 2; g++) begin
            check("write_go", w_go[g], 1'b0);
            check("erase_go", e_go[g], 1'b0);
        end
        n = 0;
        while (done[0] !== 1'b1 && n < 300) begin
            step();
            n++;
        end
        if (done[0] !== 1'b1) begin
            fail_count++;
            wrap_up();
        end
        step();
        freq = 1'b1;
        for (int g = 0; g < 2; g++) begin
            check("cpu_stall", stall[g], 1'b0);
        end
        foreach (fa[i]) begin
            faddr = fa[i];
            step();
            for (int g = 0; g < 2; g++) begin
                check("rww_access_blocked", blk[g], rww_region[g] && fa[i] < limit(g));
            end
        end
        freq = 1'b0;
        load = is_wr;
        reen = !is_wr;
        step();
        load = 1'b0;
        reen = 1'b0;
        step();
        for (int g = 0; g < 2; g++) begin
            check("rww_busy_flag", busy[g], 1'b0);
        end
    endtask

    initial begin
        t_bounds();
        t_pointer();
        t_prog(16'hE400, 1'b1, 8'h14);
        t_prog(16'hBF80, 1'b0, 8'h3C);
        t_prog(16'h0040, 1'b0, 8'h01);
        t_prog(16'hFF80, 1'b1, 8'h03);
        wrap_up();
    end
endmodule
`default_nettype wire
